// ===== logic/crpg_gate.sv
// access gate that applies the code read protection level to debug and serial paths
`timescale 1ns/100ps
`default_nettype none
module crpg_gate (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // stored protection word from the dedicated flash location
    input wire logic [31:0] pattern,
    input wire logic pattern_valid,
    // boundary-scan debug request from the probe
    input wire logic debug_req,
    // boot-time entry pin, active low
    input wire logic programming_entry_pin_n,
    // application request to re-enter serial programming mode
    input wire logic app_reinvoke,
    // serial programming command from the host
    input wire logic isp_cmd_valid,
    input wire logic [3:0] isp_cmd,
    input wire logic [4:0] isp_sector_lo,
    input wire logic [4:0] isp_sector_hi,
    // application programming call
    input wire logic iap_cmd_valid,
    input wire logic [3:0] iap_cmd,
    input wire logic [4:0] iap_sector_lo,
    input wire logic [4:0] iap_sector_hi,
    // protection level held since reset
    output logic [1:0] read_protection,
    output logic level_latched,
    // debug port enable
    output logic debug_enable,
    // serial programming mode active
    output logic serial_programming_mode,
    // serial command verdict, one-cycle pulses
    output logic isp_accept,
    output logic isp_reject,
    output logic [3:0] isp_cmd_out,
    output logic [4:0] isp_sector_lo_out,
    output logic [4:0] isp_sector_hi_out,
    // application call passed through, one-cycle pulse
    output logic iap_issue,
    output logic [3:0] iap_cmd_out,
    output logic [4:0] iap_sector_lo_out,
    output logic [4:0] iap_sector_hi_out
);
    // reset synchroniser stages; only the second is used
    logic rst_meta;
    logic rst_sync;
    // decoded level from the live pattern
    crpg_pkg::crpg_level_e decoded;
    // held level, taken once after reset release
    crpg_pkg::crpg_level_e level;
    // set once the level has been captured
    logic captured;
    // whole-device erase has happened at level two
    logic erased;
    // combinational command verdict
    logic next_accept;
    logic sector0_touch;
    logic full_range;

    // two-stage release of the asynchronous reset
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // pattern compare lives in its own small decoder
    crpg_level_decode u_decode (
        .pattern(pattern),
        .level(decoded)
    );

    // capture the level once, when flash has delivered the pattern
    // the latch never reopens, so a later flash write cannot loosen it
    // pattern_valid may stay high; the captured flag alone blocks a second take
    always_ff @(posedge ref_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            level <= crpg_pkg::CRPG_LEVEL_THREE; // strictest until known
            captured <= 1'b0;
        end else if (!captured && pattern_valid) begin
            level <= decoded;
            captured <= 1'b1;
        end
    end

    // level outputs follow the held level
    always_ff @(posedge ref_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            read_protection <= 2'b11;
            level_latched <= 1'b0;
        end else begin
            read_protection <= level;
            level_latched <= captured;
        end
    end

    // debug port is only open with no protection and a captured level
    // held closed before capture so a probe cannot slip in during boot
    always_ff @(posedge ref_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            debug_enable <= 1'b0;
        end else begin
            debug_enable <= captured && (level == crpg_pkg::CRPG_OPEN);
        end
    end

    // serial programming entry: pin at boot, or the application's request
    // mode is sticky: only a reset leaves it
    always_ff @(posedge ref_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            serial_programming_mode <= 1'b0;
        end else if (app_reinvoke && captured) begin
            serial_programming_mode <= 1'b1; // honoured at every level
        end else if (!captured && pattern_valid && !programming_entry_pin_n) begin
            // pin only counts at boot, and not at level three
            serial_programming_mode <= (decoded != crpg_pkg::CRPG_LEVEL_THREE);
        end
    end

    // sector range checks for the host command
    // a range starting at sector 0 always covers it, so lo alone decides
    assign sector0_touch = (isp_sector_lo == crpg_pkg::SECTOR_BOOT);
    assign full_range = (isp_sector_lo == crpg_pkg::SECTOR_BOOT) && (isp_sector_hi == crpg_pkg::SECTOR_LAST);

    // command filter per level
    // reads, compares and jumps are never in a protected subset
    always_comb begin
        next_accept = 1'b0;
        unique case (level)
            crpg_pkg::CRPG_OPEN: begin
                next_accept = 1'b1;
            end
            crpg_pkg::CRPG_LEVEL_ONE: begin
                // no reads or compares; writes and erases avoid sector 0
                unique case (isp_cmd)
                    crpg_pkg::CMD_UNLOCK, crpg_pkg::CMD_WRITE_RAM, crpg_pkg::CMD_BLANK_CHECK,
                    crpg_pkg::CMD_READ_ID: next_accept = 1'b1;
                    crpg_pkg::CMD_PREPARE, crpg_pkg::CMD_ERASE,
                    crpg_pkg::CMD_COPY_TO_FLASH: next_accept = !sector0_touch;
                    default: next_accept = 1'b0;
                endcase
            end
            crpg_pkg::CRPG_LEVEL_TWO: begin
                // only unlock, ID read and a whole prepare or erase, then writes and any prepare or erase once the part is blank
                unique case (isp_cmd)
                    crpg_pkg::CMD_UNLOCK, crpg_pkg::CMD_READ_ID: next_accept = 1'b1;
                    crpg_pkg::CMD_PREPARE, crpg_pkg::CMD_ERASE: next_accept = full_range || erased;
                    crpg_pkg::CMD_WRITE_RAM, crpg_pkg::CMD_COPY_TO_FLASH: next_accept = erased;
                    default: next_accept = 1'b0;
                endcase
            end
            crpg_pkg::CRPG_LEVEL_THREE: begin
                next_accept = 1'b0;
            end
        endcase
    end

    // level two remembers a completed whole erase until reset
    always_ff @(posedge ref_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            erased <= 1'b0;
        end else if (isp_cmd_valid && serial_programming_mode && level == crpg_pkg::CRPG_LEVEL_TWO
                     && isp_cmd == crpg_pkg::CMD_ERASE && full_range) begin
            erased <= 1'b1;
        end
    end

    // serial command verdict; nothing passes outside programming mode
    // commands are rejected rather than dropped so the host always sees a verdict
    // the copies of command and sectors follow every strobe, accepted or not
    always_ff @(posedge ref_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            isp_accept <= 1'b0;
            isp_reject <= 1'b0;
            isp_cmd_out <= 4'h0;
            isp_sector_lo_out <= 5'h00;
            isp_sector_hi_out <= 5'h00;
        end else begin
            isp_accept <= isp_cmd_valid && serial_programming_mode && next_accept;
            isp_reject <= isp_cmd_valid && !(serial_programming_mode && next_accept);
            isp_cmd_out <= isp_cmd;
            isp_sector_lo_out <= isp_sector_lo;
            isp_sector_hi_out <= isp_sector_hi;
        end
    end

    // application calls pass with one register stage and no filter
    // a filter here would break updates that the application owns
    always_ff @(posedge ref_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            iap_issue <= 1'b0;
            iap_cmd_out <= 4'h0;
            iap_sector_lo_out <= 5'h00;
            iap_sector_hi_out <= 5'h00;
        end else begin
            iap_issue <= iap_cmd_valid;
            iap_cmd_out <= iap_cmd;
            iap_sector_lo_out <= iap_sector_lo;
            iap_sector_hi_out <= iap_sector_hi;
        end
    end

    // the test clock limit is the probe's duty; debug_req is not timed here
    logic unused_debug_req;
    assign unused_debug_req = debug_req;
endmodule
`default_nettype wire

// ===== logic/crpg_pkg.sv
// package of constants for the code read protection gate
package crpg_pkg;
    // width of the stored protection pattern word
    localparam int unsigned PATTERN_W = 32;
    // protection patterns held at the dedicated flash location (plain defaults)
    localparam logic [31:0] PATTERN_LEVEL_ONE = 32'h12345678;
    localparam logic [31:0] PATTERN_LEVEL_TWO = 32'h87654321;
    localparam logic [31:0] PATTERN_LEVEL_THREE = 32'h43218765;
    // serial programming command codes
    localparam int unsigned CMD_W = 4;
    localparam logic [3:0] CMD_UNLOCK = 4'h0;
    localparam logic [3:0] CMD_READ = 4'h1;
    localparam logic [3:0] CMD_WRITE_RAM = 4'h2;
    localparam logic [3:0] CMD_PREPARE = 4'h3;
    localparam logic [3:0] CMD_COPY_TO_FLASH = 4'h4;
    localparam logic [3:0] CMD_ERASE = 4'h5;
    localparam logic [3:0] CMD_BLANK_CHECK = 4'h6;
    localparam logic [3:0] CMD_GO = 4'h7;
    localparam logic [3:0] CMD_READ_ID = 4'h8;
    localparam logic [3:0] CMD_COMPARE = 4'h9;
    // sector numbers
    localparam int unsigned SECTOR_W = 5;
    localparam logic [4:0] SECTOR_BOOT = 5'h00;
    localparam logic [4:0] SECTOR_LAST = 5'h1B;
    // protection level encoding
    typedef enum logic [1:0] {
        CRPG_OPEN = 2'b00,
        CRPG_LEVEL_ONE = 2'b01,
        CRPG_LEVEL_TWO = 2'b10,
        CRPG_LEVEL_THREE = 2'b11
    } crpg_level_e;
endpackage

// ===== logic/crpg_level_decode.sv
// decoder from the stored protection pattern to a protection level
`timescale 1ns/100ps
`default_nettype none
module crpg_level_decode (
    // stored pattern word
    input wire logic [31:0] pattern,
    // decoded level
    output var crpg_pkg::crpg_level_e level
);
    // any other value leaves the device open
    always_comb begin
        if (pattern == crpg_pkg::PATTERN_LEVEL_ONE) begin
            level = crpg_pkg::CRPG_LEVEL_ONE;
        end else if (pattern == crpg_pkg::PATTERN_LEVEL_TWO) begin
            level = crpg_pkg::CRPG_LEVEL_TWO;
        end else if (pattern == crpg_pkg::PATTERN_LEVEL_THREE) begin
            level = crpg_pkg::CRPG_LEVEL_THREE;
        end else begin
            level = crpg_pkg::CRPG_OPEN;
        end
    end
endmodule
`default_nettype wire

// ===== test/crpg_gate_properties.sv
// assertions on the ports of the code read protection gate
`timescale 1ns/100ps
`default_nettype none
module crpg_checker (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // requests into the gate
    input wire logic isp_cmd_valid,
    input wire logic [3:0] isp_cmd,
    input wire logic [4:0] isp_sector_lo,
    input wire logic iap_cmd_valid,
    input wire logic [3:0] iap_cmd,
    input wire logic app_reinvoke,
    // results of the gate
    input wire logic [1:0] read_protection,
    input wire logic level_latched,
    input wire logic debug_enable,
    input wire logic serial_programming_mode,
    input wire logic isp_accept,
    input wire logic isp_reject,
    input wire logic iap_issue,
    input wire logic [3:0] iap_cmd_out
);
    // one domain, so clock and reset are given once
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    app_call_pass_a: assert property (iap_cmd_valid |=> iap_issue && iap_cmd_out == $past(iap_cmd))
        else $error("application call not passed");
    host_verdict_a: assert property (isp_cmd_valid |=> isp_accept != isp_reject)
        else $error("host command without single verdict");
    level_three_refuse_a: assert property (isp_cmd_valid && read_protection == 2'b11 |=> isp_reject)
        else $error("host command passed at level three");
    boot_sector_guard_a: assert property (level_latched && read_protection == 2'b01 && isp_cmd_valid
        && isp_cmd == crpg_pkg::CMD_ERASE && isp_sector_lo == crpg_pkg::SECTOR_BOOT |=> isp_reject)
        else $error("boot sector erased at level one");
    debug_match_a: assert property (level_latched |-> debug_enable == (read_protection == 2'b00))
        else $error("debug port state wrong for level");
    level_hold_a: assert property (level_latched |=> level_latched && $stable(read_protection))
        else $error("level changed after capture");
    open_accept_a: assert property (level_latched && read_protection == 2'b00 && serial_programming_mode
        && isp_cmd_valid |=> isp_accept)
        else $error("open level refused a command");
    reinvoke_enter_a: assert property (level_latched && app_reinvoke |-> ##[1:2] serial_programming_mode)
        else $error("reinvoke did not enter mode");
endmodule
bind crpg_gate crpg_checker chk (.ref_clk, .rstn, .isp_cmd_valid, .isp_cmd, .isp_sector_lo, .iap_cmd_valid,
    .iap_cmd, .app_reinvoke, .read_protection, .level_latched, .debug_enable, .serial_programming_mode,
    .isp_accept, .isp_reject, .iap_issue, .iap_cmd_out);
`default_nettype wire

// ===== test/crpg_host_model.sv
// serial programming host and debug probe on the far side of the gate
`timescale 1ns/100ps
`default_nettype none
module crpg_host_model (
    // clock
    input wire logic ref_clk,
    // host command lines
    output logic isp_cmd_valid,
    output logic [3:0] isp_cmd,
    output logic [4:0] isp_sector_lo,
    output logic [4:0] isp_sector_hi,
    // probe and boot pin
    output logic debug_req,
    output logic programming_entry_pin_n
);
    // idle lines at time zero, boot pin released high
    initial begin
        {isp_cmd_valid, isp_cmd, isp_sector_lo, isp_sector_hi, debug_req} = '0;
        programming_entry_pin_n = 1'b1;
    end
    // probe toggles every 12 core cycles (a 24-cycle period), far below one sixth of it
    always begin
        repeat (12) @(posedge ref_clk);
        debug_req <= ~debug_req;
    end
    // boot pin level for the next capture
    task automatic set_pin(input logic v);
        programming_entry_pin_n <= v;
    endtask
    // one command strobe; released lines show the inverse so stale data is not mistaken
    task automatic send(input logic [3:0] c, input logic [4:0] lo, input logic [4:0] hi);
        {isp_cmd_valid, isp_cmd, isp_sector_lo, isp_sector_hi} <= {1'b1, c, lo, hi};
        @(posedge ref_clk);
        {isp_cmd_valid, isp_cmd, isp_sector_lo, isp_sector_hi} <= {1'b0, ~c, ~lo, ~hi};
    endtask
endmodule
`default_nettype wire

// ===== test/crpg_gate_tb.sv
// self-checking bench for the code read protection gate
`timescale 1ns/100ps
`default_nettype none
module crpg_gate_tb;
    // row: stored word, boot pin, command, sectors, then level, debug, mode, verdict
    typedef struct packed {
        logic [31:0] pat;
        logic pin_n;
        logic [13:0] req;
        logic [1:0] lvl;
        logic [2:0] res;
    } crpg_row_s;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic [31:0] pattern = '0;
    logic pattern_valid = 1'b0;
    logic app_reinvoke = 1'b0;
    logic iap_cmd_valid = 1'b0;
    logic [3:0] iap_cmd = '0;
    wire logic isp_cmd_valid, debug_req, pin_n, level_latched, debug_enable, mode, isp_accept, isp_reject, iap_issue;
    wire logic [3:0] isp_cmd, isp_cmd_out, iap_cmd_out;
    wire logic [4:0] lo, hi, isp_lo_out, isp_hi_out, iap_lo_out, iap_hi_out;
    wire logic [1:0] read_protection;
    int miscompares = 0;
    int n_tests = 0;
    crpg_row_s rows [8];
    always #5 ref_clk = ~ref_clk;
    crpg_host_model host (.ref_clk, .isp_cmd_valid, .isp_cmd, .isp_sector_lo(lo), .isp_sector_hi(hi),
        .debug_req, .programming_entry_pin_n(pin_n));
    crpg_gate dut (.ref_clk, .rstn, .pattern, .pattern_valid, .debug_req, .programming_entry_pin_n(pin_n),
        .app_reinvoke, .isp_cmd_valid, .isp_cmd, .isp_sector_lo(lo), .isp_sector_hi(hi), .iap_cmd_valid,
        .iap_cmd, .iap_sector_lo(lo), .iap_sector_hi(hi), .read_protection, .level_latched, .debug_enable,
        .serial_programming_mode(mode), .isp_accept, .isp_reject, .isp_cmd_out, .isp_sector_lo_out(isp_lo_out),
        .isp_sector_hi_out(isp_hi_out), .iap_issue, .iap_cmd_out, .iap_sector_lo_out(iap_lo_out),
        .iap_sector_hi_out(iap_hi_out));
    // one compare for every result, widened to sixteen bits
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    // reset for 12 cycles, then offer the stored word and wait for the capture
    task automatic boot(input logic [31:0] p, input logic pn);
        @(posedge ref_clk);
        {rstn, pattern_valid} <= 2'b00;
        host.set_pin(pn);
        repeat (12) @(posedge ref_clk);
        {rstn, pattern} <= {1'b1, p};
        repeat (3) @(posedge ref_clk);
        pattern_valid <= 1'b1;
        for (int i = 0; i < 20 && level_latched !== 1'b1; i++) @(posedge ref_clk);
        #1;
    endtask
    // host command and application call side by side, verdict one cycle on
    task automatic cmd(input logic [13:0] r, input logic acc);
        @(posedge ref_clk);
        {iap_cmd_valid, iap_cmd} <= {1'b1, r[13:10]};
        host.send(r[13:10], r[9:5], r[4:0]);
        iap_cmd_valid <= 1'b0;
        #1;
        chk({isp_accept, isp_reject, iap_issue}, {acc, !acc, 1'b1});
        chk({iap_cmd_out, iap_lo_out, iap_hi_out}, r);
        chk({isp_cmd_out, isp_lo_out, isp_hi_out}, r);
    endtask
    // hang guard: about 20 cycles per boot, so 10000 cycles is ample
    initial begin
        #100000;
        miscompares++;
        stop_test();
    end
    initial begin
        rows[0] = {32'h0, 1'b0, crpg_pkg::CMD_READ, 10'h0, 2'b00, 3'b111};
        rows[1] = {32'h0, 1'b1, crpg_pkg::CMD_READ, 10'h0, 2'b00, 3'b100};
        rows[2] = {crpg_pkg::PATTERN_LEVEL_ONE, 1'b0, crpg_pkg::CMD_UNLOCK, 10'h0, 2'b01, 3'b011};
        rows[3] = {crpg_pkg::PATTERN_LEVEL_ONE, 1'b0, crpg_pkg::CMD_ERASE, 10'h1, 2'b01, 3'b010};
        rows[4] = {crpg_pkg::PATTERN_LEVEL_ONE, 1'b0, crpg_pkg::CMD_ERASE, 10'h22, 2'b01, 3'b011};
        rows[5] = {crpg_pkg::PATTERN_LEVEL_TWO, 1'b0, crpg_pkg::CMD_WRITE_RAM, 10'h0, 2'b10, 3'b010};
        rows[6] = {crpg_pkg::PATTERN_LEVEL_TWO, 1'b0, crpg_pkg::CMD_ERASE, 10'h1B, 2'b10, 3'b011};
        rows[7] = {crpg_pkg::PATTERN_LEVEL_THREE, 1'b0, crpg_pkg::CMD_READ_ID, 10'h0, 2'b11, 3'b000};
        foreach (rows[i]) begin
            boot(rows[i].pat, rows[i].pin_n);
            chk({level_latched, read_protection}, {1'b1, rows[i].lvl});
            chk({debug_enable, mode}, rows[i].res[2:1]);
            cmd(rows[i].req, rows[i].res[0]);
        end
        // level one: jumps and compares refused, a copy to flash that touches sector 0 refused
        boot(crpg_pkg::PATTERN_LEVEL_ONE, 1'b0);
        cmd({crpg_pkg::CMD_GO, 10'h0}, 1'b0);
        cmd({crpg_pkg::CMD_COMPARE, 10'h43}, 1'b0);
        cmd({crpg_pkg::CMD_BLANK_CHECK, 10'h0}, 1'b1);
        cmd({crpg_pkg::CMD_COPY_TO_FLASH, 10'h3}, 1'b0);
        cmd({crpg_pkg::CMD_PREPARE, 10'h43}, 1'b1);
        // whole erase at level two opens writes; stored word changes are ignored
        boot(crpg_pkg::PATTERN_LEVEL_TWO, 1'b0);
        @(posedge ref_clk);
        pattern <= '0;
        cmd({crpg_pkg::CMD_COPY_TO_FLASH, 10'h0}, 1'b0);
        cmd({crpg_pkg::CMD_PREPARE, 10'h43}, 1'b0);
        cmd({crpg_pkg::CMD_ERASE, 10'h1B}, 1'b1);
        cmd({crpg_pkg::CMD_WRITE_RAM, 10'h0}, 1'b1);
        cmd({crpg_pkg::CMD_PREPARE, 10'h43}, 1'b1);
        cmd({crpg_pkg::CMD_COPY_TO_FLASH, 10'h0}, 1'b1);
        chk(read_protection, 2'b10);
        // level three: application reinvoke still enters the mode
        boot(crpg_pkg::PATTERN_LEVEL_THREE, 1'b0);
        @(posedge ref_clk);
        app_reinvoke <= 1'b1;
        @(posedge ref_clk);
        app_reinvoke <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        chk(mode, 1'b1);
        cmd({crpg_pkg::CMD_READ, 10'h0}, 1'b0);
        // reset in mid-run drops the held level back to strict
        @(posedge ref_clk);
        rstn <= 1'b0;
        #1;
        chk({level_latched, read_protection}, 3'b011);
        stop_test();
    end
    // verdict and end of run
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
endmodule
`default_nettype wire
